/* design/vicrq_controller.sv */
// Implementation choice: the APB interface to the registers.
`default_nettype none

module vicrq_controller
#(
    parameter int ADDR_W       = 12,                        // APB address width.
    parameter int STACK_LEVELS = vicrq_pkg::STACK_LEVELS    // Return stack depth.
)
(
    input  wire logic              pclk,                  // System clock.
    input  wire logic              presetn,               // Asynchronous reset, active low.
    input  wire logic              psel,                  // APB select.
    input  wire logic              penable,               // APB access phase.
    input  wire logic              pwrite,                // APB write when high.
    input  wire logic [ADDR_W-1:0] paddr,                 // APB byte address.
    input  wire logic [31:0]       pwdata,                // APB write data.
    output logic      [31:0]       prdata,                // APB read data.
    output logic                   pready,                // APB ready.
    output logic                   pslverr,               // APB error on unmapped address.
    input  wire logic              ext_irq_pin_n,         // External request pin.
    input  wire logic              counter0_overflow,     // Counter 0 overflow pulse.
    input  wire logic              counter1_overflow,     // Counter 1 overflow pulse.
    input  wire logic              transmit_enable_flag,  // Serial transmit buffer free.
    input  wire logic              receive_complete_flag, // Serial byte received.
    input  wire logic              transmit_idle_flag,    // Serial transmitter idle.
    input  wire logic              receive_idle_flag,     // Serial receiver idle.
    input  wire logic              slave_address_matched, // Two-wire address matched.
    input  wire logic              two_wire_byte_done,    // Two-wire byte done pulse.
    input  wire logic              counter2_overflow,     // Counter 2 overflow pulse.
    input  wire logic              timebase_timeout,      // Time base time-out pulse.
    input  wire logic              rtc_timeout,           // Real time clock time-out pulse.
    input  wire logic              phase_two_clock,       // Phase-two sampling strobe.
    input  wire logic [4:0]        stack_pointer,         // Return stack fill level.
    input  wire logic              irq_return_reenable,   // Return-with-reenable pulse.
    input  wire logic              halted,                // Core is in halt.
    output logic                   irq_call,              // Push PC and branch, one cycle.
    output logic      [7:0]        irq_vector,            // Branch target of the call.
    output logic                   wake_up,               // Wake request to the core.
    output logic                   global_irq_enable      // Current global enable.
);

    // A full stack must be reachable by the five-bit stack pointer.
    if (ADDR_W < 10 || STACK_LEVELS < 1 || STACK_LEVELS > 31)
    begin : g_param_check
        $error("vicrq_controller: unsupported parameter values");
    end

    localparam logic [4:0] STACK_FULL = 5'(STACK_LEVELS);

    function automatic vicrq_pkg::vicrq_reg_type decode_reg(input logic [ADDR_W-1:0] a);
        vicrq_pkg::vicrq_reg_type r;
        r = vicrq_pkg::REG_NONE;
        if (a[1:0] == 2'h0)
        begin
            if (a[ADDR_W-1:2] == (ADDR_W-2)'(vicrq_pkg::REG_IDX_CONTROL0))
            begin
                r = vicrq_pkg::REG_CONTROL0;
            end
            else if (a[ADDR_W-1:2] == (ADDR_W-2)'(vicrq_pkg::REG_IDX_CONTROL1))
            begin
                r = vicrq_pkg::REG_CONTROL1;
            end
            else if (a[ADDR_W-1:2] == (ADDR_W-2)'(vicrq_pkg::REG_IDX_GROUP))
            begin
                r = vicrq_pkg::REG_GROUP;
            end
        end
        return r;
    endfunction : decode_reg

    function automatic logic [7:0] vector_of(input int src);
        logic [7:0] v;
        v = vicrq_pkg::VEC_NONE;
        unique case (src)
            vicrq_pkg::SRC_EXT:   v = vicrq_pkg::VEC_EXT;
            vicrq_pkg::SRC_CNT0:  v = vicrq_pkg::VEC_CNT0;
            vicrq_pkg::SRC_CNT1:  v = vicrq_pkg::VEC_CNT1;
            vicrq_pkg::SRC_UART:  v = vicrq_pkg::VEC_UART;
            vicrq_pkg::SRC_TWI:   v = vicrq_pkg::VEC_TWI;
            vicrq_pkg::SRC_GROUP: v = vicrq_pkg::VEC_GROUP;
            default:              v = vicrq_pkg::VEC_NONE;
        endcase
        return v;
    endfunction : vector_of

    // Register state.
    logic                            global_en_r;
    logic                            test_bit_r;
    logic [vicrq_pkg::NUM_SRC-1:0]   src_en_r;
    logic [vicrq_pkg::NUM_SRC-1:0]   src_flag_r;
    logic [vicrq_pkg::NUM_SUB-1:0]   sub_en_r;
    logic [vicrq_pkg::NUM_SUB-1:0]   sub_flag_r;
    logic [31:0]                     rdata_r;
    logic                            call_r;
    logic [7:0]                      vector_r;
    logic                            wake_r;
    logic                            sa_match_prev_r;
    logic [3:0]                      uart_prev_r;

    // Combinational helpers.
    logic                            ext_fall;
    logic [3:0]                      uart_now;
    logic [vicrq_pkg::NUM_SRC-1:0]   hw_set;
    logic [vicrq_pkg::NUM_SUB-1:0]   sub_set;
    logic [vicrq_pkg::NUM_SRC-1:0]   eligible;
    logic [vicrq_pkg::NUM_SRC-1:0]   ack_clear;
    logic                            stack_full;
    logic                            accept;
    logic [7:0]                      accept_vector;
    logic                            wr_access;
    vicrq_pkg::vicrq_reg_type        wr_sel;
    vicrq_pkg::vicrq_reg_type        rd_sel;

    vicrq_pin_edge vicrq_pin_edge_inst
    (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin_n      (ext_irq_pin_n),
        .fall_pulse (ext_fall)
    );

    assign uart_now = {receive_idle_flag, transmit_idle_flag,
                       receive_complete_flag, transmit_enable_flag};

    // Level conditions set a flag once per rise, so a flag cleared by
    // software is not raised again while the condition merely persists.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uart_prev_r     <= 4'h0;
            sa_match_prev_r <= 1'b0;
        end
        else
        begin
            uart_prev_r     <= uart_now;
            sa_match_prev_r <= slave_address_matched;
        end
    end

    assign sub_set[vicrq_pkg::SUB_CNT2] = counter2_overflow;
    assign sub_set[vicrq_pkg::SUB_TB]   = timebase_timeout;
    assign sub_set[vicrq_pkg::SUB_RTC]  = rtc_timeout;

    always_comb
    begin
        hw_set                      = '0;
        hw_set[vicrq_pkg::SRC_EXT]  = ext_fall;
        hw_set[vicrq_pkg::SRC_CNT0] = counter0_overflow;
        hw_set[vicrq_pkg::SRC_CNT1] = counter1_overflow;
        hw_set[vicrq_pkg::SRC_UART] = |(uart_now & ~uart_prev_r);
        hw_set[vicrq_pkg::SRC_TWI]  = (slave_address_matched & ~sa_match_prev_r)
                                      | two_wire_byte_done;
        hw_set[vicrq_pkg::SRC_GROUP] = |(sub_set & sub_en_r);
    end

    assign stack_full = (stack_pointer >= STACK_FULL);
    assign eligible   = src_flag_r & src_en_r & {vicrq_pkg::NUM_SRC{global_en_r}};

    // Fixed priority: the lowest index wins.
    always_comb
    begin
        ack_clear     = '0;
        accept_vector = vicrq_pkg::VEC_NONE;
        for (int i = vicrq_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                ack_clear     = '0;
                ack_clear[i]  = 1'b1;
                accept_vector = vector_of(i);
            end
        end
    end

    // Acceptance happens only on the phase-two strobe, and only the highest priority
    // eligible request is served at it; the others wait for a later strobe.
    assign accept = phase_two_clock & ~stack_full & (|eligible);

    assign wr_access = psel & penable & pwrite;
    assign wr_sel    = decode_reg(paddr);
    assign rd_sel    = decode_reg(paddr);

    // Global enable: return-with-reenable beats a write, a write beats the
    // clearing on acceptance.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            global_en_r <= vicrq_pkg::RESET_CONTROL0[vicrq_pkg::BIT_GLOBAL_EN];
            test_bit_r  <= vicrq_pkg::RESET_CONTROL0[vicrq_pkg::BIT_TEST_MODE];
        end
        else
        begin
            if (irq_return_reenable)
            begin
                global_en_r <= 1'b1;
            end
            else if (wr_access && wr_sel == vicrq_pkg::REG_CONTROL0)
            begin
                global_en_r <= pwdata[vicrq_pkg::BIT_GLOBAL_EN];
            end
            else if (accept)
            begin
                global_en_r <= 1'b0;
            end
            if (wr_access && wr_sel == vicrq_pkg::REG_CONTROL0)
            begin
                // Stored and read back only; it steers nothing here.
                test_bit_r <= pwdata[vicrq_pkg::BIT_TEST_MODE];
            end
        end
    end

    // Source enables.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_en_r <= {vicrq_pkg::RESET_CONTROL1[vicrq_pkg::EN_LSB +: 3],
                         vicrq_pkg::RESET_CONTROL0[vicrq_pkg::EN_LSB + 1 +: 3]};
            sub_en_r <= vicrq_pkg::RESET_GROUP[vicrq_pkg::EN_LSB +: vicrq_pkg::NUM_SUB];
        end
        else if (wr_access)
        begin
            unique case (wr_sel)
                vicrq_pkg::REG_CONTROL0: src_en_r[2:0] <= pwdata[3:1];
                vicrq_pkg::REG_CONTROL1: src_en_r[5:3] <= pwdata[2:0];
                vicrq_pkg::REG_GROUP:    sub_en_r      <= pwdata[2:0];
                vicrq_pkg::REG_NONE:     ;
            endcase
        end
    end

    // Request flags: hardware set first, then software write, then acceptance.
    genvar g;
    generate
        for (g = 0; g < vicrq_pkg::NUM_SRC; g++)
        begin : g_flag
            localparam vicrq_pkg::vicrq_reg_type OWNER =
                (g < 3) ? vicrq_pkg::REG_CONTROL0 : vicrq_pkg::REG_CONTROL1;
            localparam int FBIT = vicrq_pkg::FLAG_LSB + (g % 3);
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    src_flag_r[g] <= 1'b0;
                end
                else if (hw_set[g])
                begin
                    src_flag_r[g] <= 1'b1;
                end
                else if (wr_access && wr_sel == OWNER)
                begin
                    src_flag_r[g] <= pwdata[FBIT];
                end
                else if (accept && ack_clear[g])
                begin
                    src_flag_r[g] <= 1'b0;
                end
            end
        end
        for (g = 0; g < vicrq_pkg::NUM_SUB; g++)
        begin : g_sub
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sub_flag_r[g] <= 1'b0;
                end
                else if (sub_set[g])
                begin
                    sub_flag_r[g] <= 1'b1;
                end
                else if (wr_access && wr_sel == vicrq_pkg::REG_GROUP)
                begin
                    // Only a write clears these; acceptance and reads do not.
                    sub_flag_r[g] <= pwdata[vicrq_pkg::FLAG_LSB + g];
                end
            end
        end
    endgenerate

    // Call output: a one-cycle pulse carrying the vector; the core pushes the
    // program counter alone and branches, any other context is software's job.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            call_r   <= 1'b0;
            vector_r <= vicrq_pkg::VEC_NONE;
        end
        else
        begin
            call_r <= accept;
            if (accept)
            begin
                vector_r <= accept_vector;
            end
        end
    end

    // Wake ignores the global enable and the phase-two strobe, since in halt
    // the strobe may not run at all.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_r <= 1'b0;
        end
        else
        begin
            wake_r <= halted & (|(src_flag_r & src_en_r));
        end
    end

    // Read data is captured in the setup phase and presented in the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            unique case (rd_sel)
                vicrq_pkg::REG_CONTROL0:
                    rdata_r <= {24'h00_0000, test_bit_r, src_flag_r[2:0],
                                src_en_r[2:0], global_en_r};
                vicrq_pkg::REG_CONTROL1:
                    rdata_r <= {24'h00_0000, 1'b0, src_flag_r[5:3],
                                1'b0, src_en_r[5:3]};
                vicrq_pkg::REG_GROUP:
                    rdata_r <= {24'h00_0000, 1'b0, sub_flag_r, 1'b0, sub_en_r};
                vicrq_pkg::REG_NONE:
                    rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata            = rdata_r;
    assign pready            = 1'b1;
    assign pslverr           = psel & penable & (rd_sel == vicrq_pkg::REG_NONE);
    assign irq_call          = call_r;
    assign irq_vector        = vector_r;
    assign wake_up           = wake_r;
    assign global_irq_enable = global_en_r;

endmodule : vicrq_controller

`default_nettype wire

/* design/vicrq_pkg.sv */
`default_nettype none

package vicrq_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] REG_IDX_CONTROL0 = 8'h0b;
    localparam logic [7:0] REG_IDX_CONTROL1 = 8'h1e;
    localparam logic [7:0] REG_IDX_GROUP    = 8'h2f;

    // Field positions; global enable and test mode are in CONTROL0 only, where the enables start at EN_LSB + 1.
    localparam int BIT_GLOBAL_EN = 0;
    localparam int BIT_TEST_MODE = 7;
    localparam int EN_LSB        = 0;
    localparam int FLAG_LSB      = 4;

    // Values after reset.
    localparam logic [7:0] RESET_CONTROL0 = 8'h00;
    localparam logic [7:0] RESET_CONTROL1 = 8'h00;
    localparam logic [7:0] RESET_GROUP    = 8'h00;

    // Sources in priority order, index 0 is served first.
    localparam int NUM_SRC   = 6;
    localparam int SRC_EXT   = 0;
    localparam int SRC_CNT0  = 1;
    localparam int SRC_CNT1  = 2;
    localparam int SRC_UART  = 3;
    localparam int SRC_TWI   = 4;
    localparam int SRC_GROUP = 5;

    // Group sub-sources.
    localparam int NUM_SUB  = 3;
    localparam int SUB_CNT2 = 0;
    localparam int SUB_TB   = 1;
    localparam int SUB_RTC  = 2;

    // Fixed call addresses.
    localparam logic [7:0] VEC_NONE  = 8'h00;
    localparam logic [7:0] VEC_EXT   = 8'h04;
    localparam logic [7:0] VEC_CNT0  = 8'h08;
    localparam logic [7:0] VEC_CNT1  = 8'h0c;
    localparam logic [7:0] VEC_UART  = 8'h10;
    localparam logic [7:0] VEC_TWI   = 8'h14;
    localparam logic [7:0] VEC_GROUP = 8'h18;

    localparam int STACK_LEVELS = 16;

    typedef enum logic [1:0] {
        REG_NONE,
        REG_CONTROL0,
        REG_CONTROL1,
        REG_GROUP
    } vicrq_reg_type;

endpackage : vicrq_pkg

`default_nettype wire

/* design/vicrq_pin_edge.sv */
`default_nettype none

// Brings the external request pin into the pclk domain and flags its falling edge.
module vicrq_pin_edge
(
    input  wire logic pclk,      // System clock.
    input  wire logic presetn,   // Asynchronous reset, active low.
    input  wire logic pin_n,     // Asynchronous pin level.
    output logic      fall_pulse // One cycle on a high-to-low transition.
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // The pin idles high, so reset to high avoids a false edge after release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end
        else
        begin
            meta_r <= pin_n;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign fall_pulse = prev_r & ~sync_r;

endmodule : vicrq_pin_edge

`default_nettype wire

/* test/vicrq_core_model.sv */
`default_nettype none

// Stands in for the core: makes the phase-two strobe and keeps the return stack depth.
module vicrq_core_model
(
    input  wire logic       pclk,               // System clock.
    input  wire logic       presetn,            // Reset, active low.
    input  wire logic       irq_call,           // Call pulse from the block.
    input  wire logic       return_req,         // Bench asks for a return.
    input  wire logic       fill,               // Bench forces a full stack.
    output logic            phase_two_clock,    // One strobe every four cycles.
    output logic      [4:0] stack_pointer,      // Fill level seen by the block.
    output logic            irq_return_reenable // Return-with-reenable pulse.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] phase_r;
    logic [4:0] depth_r;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            phase_r <= 2'h0;
        else
            phase_r <= phase_r + 2'h1;

    assign phase_two_clock = (phase_r == 2'h3);

    // The stack only reaches full when the bench commands it, so service stays prompt.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            depth_r <= 5'h00;
        else if (irq_call)
            depth_r <= depth_r + 5'h01;
        else if (irq_return_reenable && depth_r != 5'h00)
            depth_r <= depth_r - 5'h01;

    assign stack_pointer = fill ? 5'h10 : depth_r;

    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            irq_return_reenable <= 1'b0;
        else
            irq_return_reenable <= return_req;

endmodule : vicrq_core_model

`default_nettype wire

/* test/vicrq_controller_sva.sv */
`default_nettype none

module vicrq_controller_sva
#(
    parameter int ADDR_W       = 12, // Address width.
    parameter int STACK_LEVELS = 16  // Stack depth.
)
(
    input wire logic              pclk,                // Clock.
    input wire logic              presetn,             // Reset, active low.
    input wire logic              psel,                // Select.
    input wire logic              penable,             // Access phase.
    input wire logic              pwrite,              // Write.
    input wire logic [ADDR_W-1:0] paddr,               // Address.
    input wire logic [31:0]       prdata,              // Read data.
    input wire logic              phase_two_clock,     // Strobe.
    input wire logic [4:0]        stack_pointer,       // Stack level.
    input wire logic              irq_return_reenable, // Return pulse.
    input wire logic              halted,              // Halt.
    input wire logic              irq_call,            // Call.
    input wire logic [7:0]        irq_vector,          // Vector.
    input wire logic              wake_up,             // Wake.
    input wire logic              global_irq_enable    // Global enable.
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_call;
        irq_call ##1 !irq_call;
    endsequence

    sequence s_return;
        irq_return_reenable ##1 global_irq_enable;
    endsequence

    AST_CALL_PULSE: assert property (irq_call |-> s_call)
        else $error("call pulse longer than one cycle");
    AST_CALL_MASKS: assert property (irq_call |-> !global_irq_enable)
        else $error("global enable still set after a call");
    AST_FULL_BLOCKS: assert property (irq_call |-> $past(stack_pointer) < STACK_LEVELS)
        else $error("call taken with a full stack");
    AST_CALL_GATED: assert property (irq_call |->
        $past(phase_two_clock) && $past(global_irq_enable))
        else $error("call taken off strobe or while masked");
    AST_VECTOR: assert property (irq_call |->
        irq_vector inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18})
        else $error("call to an unknown vector");
    AST_REENABLE: assert property (irq_return_reenable |-> s_return)
        else $error("return did not set global enable");
    AST_WAKE: assert property (wake_up |-> $past(halted))
        else $error("wake raised while running");
    AST_UNUSED_ZERO: assert property (psel && penable && !pwrite &&
        paddr inside {12'h078, 12'h0bc} |-> prdata[3] == 1'b0 && prdata[7] == 1'b0)
        else $error("unused bit reads one");
endmodule : vicrq_controller_sva

bind vicrq_controller vicrq_controller_sva #(.ADDR_W(ADDR_W), .STACK_LEVELS(STACK_LEVELS))
    vicrq_controller_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .phase_two_clock, .stack_pointer, .irq_return_reenable, .halted, .irq_call, .irq_vector,
    .wake_up, .global_irq_enable);

`default_nettype wire

/* test/vicrq_controller_tb.sv */
`default_nettype none

`define CHK(nm, ex, gt) \
    begin \
        total_checks++; \
        if ((gt) !== (ex)) \
        begin \
            error_cnt++; \
            $display("Error %s expected %h seen %h", nm, ex, gt); \
        end \
    end

module vicrq_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_C0 = 12'h02c;
    localparam logic [11:0] A_C1 = 12'h078;
    localparam logic [11:0] A_GR = 12'h0bc;

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ext_n = 1'b1, halted = 1'b0, am_lv = 1'b0, return_req = 1'b0;
    logic fill = 1'b0, phase_two_clock, irq_return_reenable, irq_call, wake_up;
    logic global_irq_enable;
    logic [3:0] ser_lv = 4'h0;
    logic [5:0] ev = 6'h00;
    logic [4:0] stack_pointer;
    logic [7:0] irq_vector;
    logic [31:0] exp_q[$];
    logic [31:0] r;
    integer seed = 32'hc4d11c91;
    int error_cnt = 0, total_checks = 0;

    vicrq_controller vicrq_controller_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin_n(ext_n),
        .counter0_overflow(ev[0]), .counter1_overflow(ev[1]), .two_wire_byte_done(ev[2]),
        .counter2_overflow(ev[3]), .timebase_timeout(ev[4]), .rtc_timeout(ev[5]),
        .transmit_enable_flag(ser_lv[0]), .receive_complete_flag(ser_lv[1]),
        .transmit_idle_flag(ser_lv[2]), .receive_idle_flag(ser_lv[3]),
        .slave_address_matched(am_lv), .phase_two_clock, .stack_pointer,
        .irq_return_reenable, .halted, .irq_call, .irq_vector, .wake_up, .global_irq_enable);

    vicrq_core_model vicrq_core_model_inst (.pclk, .presetn, .irq_call, .return_req, .fill,
        .phase_two_clock, .stack_pointer, .irq_return_reenable);

    always #4 pclk = ~pclk;

    task end_of_test;
        if (exp_q.size() != 0)
            error_cnt++;
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task take(input string nm, input logic [31:0] v);
        logic [31:0] e;
        if (exp_q.size() == 0)
        begin
            error_cnt++;
            $display("Error %s expected nothing seen %h", nm, v);
        end
        else
        begin
            e = exp_q.pop_front();
            `CHK(nm, e, v)
        end
    endtask : take

    // The result watcher: every call and every read result meets the oldest note.
    always @(posedge pclk)
    begin
        if (irq_call === 1'b1)
            take("vector", {24'h0, irq_vector});
        if (psel && penable && !pwrite && pready === 1'b1)
            take("read data", prdata);
    end

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        int n;
        n = 0;
        if (!w)
            exp_q.push_back({24'h0, e});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            end_of_test();
        end
        `CHK("slave error", (a == 12'h000), pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_call;
        int n;
        for (n = 0; n < 60 && irq_call !== 1'b1; n++)
            @(posedge pclk);
        if (irq_call !== 1'b1)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask : wait_call

    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, A_C0, 8'h00, 8'h00);
        apb(0, A_C1, 8'h00, 8'h00);
        apb(1, A_GR, 8'hff, 8'h00);
        apb(0, A_GR, 8'h00, 8'h77);
        apb(1, A_C1, 8'hff, 8'h00);
        apb(0, A_C1, 8'h00, 8'h77);
        apb(1, A_C1, 8'h07, 8'h00);
        apb(1, A_GR, 8'h01, 8'h00);
        apb(1, A_C0, 8'h0e, 8'h00);
        r = $random(seed);
        ext_n <= 1'b0;
        ser_lv[r[1:0]] <= 1'b1;
        am_lv <= r[2];
        ev <= {3'b111, !r[2], 2'b11};
        @(posedge pclk);
        ev <= 6'h00;
        repeat (8) @(posedge pclk);
        apb(0, A_C0, 8'h00, 8'h7e);
        apb(0, A_C1, 8'h00, 8'h77);
        apb(0, A_GR, 8'h00, 8'h71);
        apb(1, A_C0, 8'h7f, 8'h00);
        for (int k = 1; k <= 6; k++)
        begin
            exp_q.push_back(32'(4 * k));
            wait_call();
            `CHK("global enable", 1'b0, global_irq_enable)
            return_req <= 1'b1;
            @(posedge pclk);
            return_req <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        apb(0, A_C0, 8'h00, 8'h0f);
        apb(0, A_C1, 8'h00, 8'h07);
        apb(0, A_GR, 8'h00, 8'h71);
        fill <= 1'b1;
        apb(1, A_C0, 8'h05, 8'h00);
        // Sub-sources whose enables are off must leave the group flag clear.
        ev <= 6'h31;
        @(posedge pclk);
        ev <= 6'h00;
        repeat (12) @(posedge pclk);
        `CHK("global enable", 1'b1, global_irq_enable)
        exp_q.push_back(32'h8);
        fill <= 1'b0;
        wait_call();
        apb(0, A_C1, 8'h00, 8'h07);
        apb(1, A_C0, 8'h08, 8'h00);
        halted <= 1'b1;
        ev[1] <= 1'b1;
        @(posedge pclk);
        ev[1] <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("wake", 1'b1, wake_up)
        halted <= 1'b0;
        apb(0, 12'h000, 8'h00, 8'h00);
        repeat (2) @(posedge pclk);
        end_of_test();
    end
endmodule : vicrq_controller_tb

`default_nettype wire
